// ---- src/ppc_pad_pull_config.sv ----
// pad pull resistor configuration register bank with pad-control decode
// Functional notes
// - functional bit 0 selects pullup (1) or pulldown (0) on the irq pad, pulldown after power-up.
// - functional bit 1 set disables both irq pad resistors, clear enables the selected one.
// - functional bit 2 selects pullup (1) or pulldown (0) on the ready pad, pulldown after power-up.
// - functional bit 3 set disables both ready pad resistors, clear enables the selected one.
// - functional bit 4 set disconnects the dma request pulldown, clear connects it.
// - functional bit 5 controls the pulldowns of all bus data pads except bit 7, 1 disconnects.
// - functional bit 6 set disconnects the vbus sense pulldown, clear connects it.
// - functional bit 7 controls the bus data bit 7 pulldown alone, connected after power-up.
// - each bus output select bit at 1 enables pullup and at 0 enables pulldown.
// - select bits map cs0, cs1, address group, dma ack, read, write, bus reset, bit 7 reads 0.
// - writing the bus hard reset bit as 1 clears the bus reset pad select bit.
// - at power-up every bus output pad has pulldown enabled and pullup disabled.
// - a power-down bit at 1 disables both resistors of its group, 0 enables the selected one.
`timescale 1ns/10ps
`default_nettype none
module ppc_pad_pull_config
    import ppc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    // mcu external data space access
    input wire logic [15:0] xaddr,
    input wire logic [7:0] xwdata,
    input wire logic xwr,
    input wire logic xrd,
    output logic [7:0] xrdata,
    // pulse when the mcu writes the bus hard reset bit as 1
    input wire logic bus_hard_reset_bit,
    // functional pad controls
    output logic irq_pullup_en,
    output logic irq_pulldown_en,
    output logic rdy_pullup_en,
    output logic rdy_pulldown_en,
    output logic dmarq_pulldown_en,
    output logic data_pulldown_en,
    output logic data7_pulldown_en,
    output logic vbus_pulldown_en,
    // bus output pad controls: cs0, cs1, da, dmack, rd, wr, bus reset
    output logic [6:0] bus_pullup_en,
    output logic [6:0] bus_pulldown_en
);

    logic [7:0] func_q;
    logic [7:0] sel_q;
    logic [7:0] pwdn_q;
    logic [7:0] xrdata_d;
    logic [7:0] func_d;
    logic [7:0] sel_d;
    logic [7:0] pwdn_d;

    // address decode
    logic func_hit;
    logic sel_hit;
    logic pwdn_hit;
    logic func_wr;
    logic sel_wr;
    logic pwdn_wr;

    // functional register fields
    logic irq_sel;
    logic irq_off;
    logic rdy_sel;
    logic rdy_off;
    logic dmarq_pd_off;
    logic data_pd_off;
    logic vbus_pd_off;
    logic d7_pd_off;

    // bus output selection fields; bus reset select is the only bit hardware changes on its own
    logic cs0_sel;
    logic cs1_sel;
    logic da_sel;
    logic dmack_sel;
    logic rd_sel;
    logic wr_sel;
    logic brst_sel;

    // bus output power-down fields
    logic cs0_off;
    logic cs1_off;
    logic da_off;
    logic dmack_off;
    logic rd_off;
    logic wr_off;
    logic brst_off;

    // address compare, used by every register
    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        return a == off;
    endfunction : hit

    // reserved bit 7 is never stored, so it cannot read back as 1
    function automatic logic [7:0] bus_wval(input logic [7:0] d);
        return d & PPC_BUS_WMASK;
    endfunction : bus_wval

    // pulldown-only pads: the off bit disconnects, so the enable is its inverse
    function automatic logic pd_en(input logic off);
        return ~off;
    endfunction : pd_en

    // one address compare per register, shared by the write strobes and the read mux
    assign func_hit = hit(xaddr, PPC_FUNC_OFFSET);
    assign sel_hit = hit(xaddr, PPC_SEL_OFFSET);
    assign pwdn_hit = hit(xaddr, PPC_PWDN_OFFSET);
    assign func_wr = xwr & func_hit;
    assign sel_wr = xwr & sel_hit;
    assign pwdn_wr = xwr & pwdn_hit;

    // next functional value
    // no bit of this register is refused
    always_comb
    begin
        func_d = func_q;
        if (func_wr)
            func_d = xwdata;
    end

    // next selection value; hard reset clears the bus reset select and beats a same-cycle write
    // the hard reset strobe is taken as synchronous to mclk
    always_comb
    begin
        sel_d = sel_q;
        if (sel_wr)
            sel_d = bus_wval(xwdata);
        if (bus_hard_reset_bit)
            sel_d[PPC_S_BRST] = 1'b0;
    end

    // next power-down value, bit 7 reserved as in the selection register
    always_comb
    begin
        pwdn_d = pwdn_q;
        if (pwdn_wr)
            pwdn_d = bus_wval(xwdata);
    end

    // functional fields
    assign irq_sel = func_q[PPC_F_IRQ_SEL];
    assign irq_off = func_q[PPC_F_IRQ_OFF];
    assign rdy_sel = func_q[PPC_F_RDY_SEL];
    assign rdy_off = func_q[PPC_F_RDY_OFF];
    assign dmarq_pd_off = func_q[PPC_F_DMARQ_PD_OFF];
    assign data_pd_off = func_q[PPC_F_DATA_PD_OFF];
    assign vbus_pd_off = func_q[PPC_F_VBUS_PD_OFF];
    assign d7_pd_off = func_q[PPC_F_D7_PD_OFF];

    // selection fields
    assign cs0_sel = sel_q[PPC_S_CS0];
    assign cs1_sel = sel_q[PPC_S_CS1];
    assign da_sel = sel_q[PPC_S_DA];
    assign dmack_sel = sel_q[PPC_S_DMACK];
    assign rd_sel = sel_q[PPC_S_RD];
    assign wr_sel = sel_q[PPC_S_WR];
    assign brst_sel = sel_q[PPC_S_BRST];

    // power-down fields
    assign cs0_off = pwdn_q[PPC_S_CS0];
    assign cs1_off = pwdn_q[PPC_S_CS1];
    assign da_off = pwdn_q[PPC_S_DA];
    assign dmack_off = pwdn_q[PPC_S_DMACK];
    assign rd_off = pwdn_q[PPC_S_RD];
    assign wr_off = pwdn_q[PPC_S_WR];
    assign brst_off = pwdn_q[PPC_S_BRST];

    // functional pin register, all bits plain read/write
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            func_q <= PPC_FUNC_RESET;
        else
            func_q <= func_d;
    end

    // selection register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            sel_q <= PPC_SEL_RESET;
        else
            sel_q <= sel_d;
    end

    // companion power-down register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            pwdn_q <= PPC_PWDN_RESET;
        else
            pwdn_q <= pwdn_d;
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        xrdata_d = 8'h00;
        if (func_hit)
            xrdata_d = func_q;
        else if (sel_hit)
            xrdata_d = sel_q;
        else if (pwdn_hit)
            xrdata_d = pwdn_q;
    end

    // read data registered, valid the cycle after xrd
    // a read in the same cycle as a write returns the old value
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            xrdata <= 8'h00;
        else if (xrd)
            xrdata <= xrdata_d;
    end

    // pad enables are pure decode of the register bits, no extra flop
    // interrupt request pad
    ppc_pad_decode u_irq (
        .pull_sel(irq_sel),
        .pull_off(irq_off),
        .pullup_en(irq_pullup_en),
        .pulldown_en(irq_pulldown_en)
    );

    // ready pad; firmware has to move it to the pullup before normal operation
    ppc_pad_decode u_rdy (
        .pull_sel(rdy_sel),
        .pull_off(rdy_off),
        .pullup_en(rdy_pullup_en),
        .pulldown_en(rdy_pulldown_en)
    );

    // pulldown-only pads
    assign dmarq_pulldown_en = pd_en(dmarq_pd_off);
    assign data_pulldown_en = pd_en(data_pd_off);
    assign vbus_pulldown_en = pd_en(vbus_pd_off);
    assign data7_pulldown_en = pd_en(d7_pd_off);

    // bus output groups; pulldowns come up enabled because the bus buffers are off at power-up
    // chip select 0
    ppc_pad_decode u_cs0 (
        .pull_sel(cs0_sel),
        .pull_off(cs0_off),
        .pullup_en(bus_pullup_en[PPC_S_CS0]),
        .pulldown_en(bus_pulldown_en[PPC_S_CS0])
    );

    // chip select 1
    ppc_pad_decode u_cs1 (
        .pull_sel(cs1_sel),
        .pull_off(cs1_off),
        .pullup_en(bus_pullup_en[PPC_S_CS1]),
        .pulldown_en(bus_pulldown_en[PPC_S_CS1])
    );

    // device address group
    ppc_pad_decode u_da (
        .pull_sel(da_sel),
        .pull_off(da_off),
        .pullup_en(bus_pullup_en[PPC_S_DA]),
        .pulldown_en(bus_pulldown_en[PPC_S_DA])
    );

    // dma acknowledge
    ppc_pad_decode u_dmack (
        .pull_sel(dmack_sel),
        .pull_off(dmack_off),
        .pullup_en(bus_pullup_en[PPC_S_DMACK]),
        .pulldown_en(bus_pulldown_en[PPC_S_DMACK])
    );

    // read strobe
    ppc_pad_decode u_rd (
        .pull_sel(rd_sel),
        .pull_off(rd_off),
        .pullup_en(bus_pullup_en[PPC_S_RD]),
        .pulldown_en(bus_pulldown_en[PPC_S_RD])
    );

    // write strobe
    ppc_pad_decode u_wr (
        .pull_sel(wr_sel),
        .pull_off(wr_off),
        .pullup_en(bus_pullup_en[PPC_S_WR]),
        .pulldown_en(bus_pulldown_en[PPC_S_WR])
    );

    // bus reset, dropped to the pulldown by a hard reset
    ppc_pad_decode u_brst (
        .pull_sel(brst_sel),
        .pull_off(brst_off),
        .pullup_en(bus_pullup_en[PPC_S_BRST]),
        .pulldown_en(bus_pulldown_en[PPC_S_BRST])
    );

endmodule : ppc_pad_pull_config
`default_nettype wire

// ---- src/ppc_pkg.sv ----
// package: register map, field positions and reset values for the pad pull configuration bank
package ppc_pkg;

    localparam logic [15:0] PPC_FUNC_OFFSET = 16'hf08e;
    localparam logic [15:0] PPC_SEL_OFFSET = 16'hf08f;
    localparam logic [15:0] PPC_PWDN_OFFSET = 16'hf090;

    localparam logic [7:0] PPC_FUNC_RESET = 8'h00;
    localparam logic [7:0] PPC_SEL_RESET = 8'h00;
    localparam logic [7:0] PPC_PWDN_RESET = 8'h00;

    // functional pin register fields
    localparam int PPC_F_IRQ_SEL = 0;
    localparam int PPC_F_IRQ_OFF = 1;
    localparam int PPC_F_RDY_SEL = 2;
    localparam int PPC_F_RDY_OFF = 3;
    localparam int PPC_F_DMARQ_PD_OFF = 4;
    localparam int PPC_F_DATA_PD_OFF = 5;
    localparam int PPC_F_VBUS_PD_OFF = 6;
    localparam int PPC_F_D7_PD_OFF = 7;

    // bus output selection / power-down fields
    localparam int PPC_S_CS0 = 0;
    localparam int PPC_S_CS1 = 1;
    localparam int PPC_S_DA = 2;
    localparam int PPC_S_DMACK = 3;
    localparam int PPC_S_RD = 4;
    localparam int PPC_S_WR = 5;
    localparam int PPC_S_BRST = 6;
    localparam int PPC_S_RSV = 7;

    // writable bits of the bus output registers, bit 7 reserved
    localparam logic [7:0] PPC_BUS_WMASK = 8'h7f;

endpackage : ppc_pkg

// ---- src/ppc_pad_decode.sv ----
// pad resistor enable decode for one pad group
`timescale 1ns/10ps
`default_nettype none
module ppc_pad_decode
    import ppc_pkg::*;
(
    input wire logic pull_sel,
    input wire logic pull_off,
    output logic pullup_en,
    output logic pulldown_en
);

    assign pullup_en = pull_sel & ~pull_off;
    assign pulldown_en = ~pull_sel & ~pull_off;

endmodule : ppc_pad_decode
`default_nettype wire

// ---- test/ppc_checker_assertions.sv ----
// checker for the pad pull configuration bank
`timescale 1ns/10ps
`default_nettype none
module ppc_checker
    import ppc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [15:0] xaddr,
    input wire logic [7:0] xwdata,
    input wire logic xwr,
    input wire logic xrd,
    input wire logic [7:0] xrdata,
    input wire logic bus_hard_reset_bit,
    input wire logic irq_pullup_en,
    input wire logic irq_pulldown_en,
    input wire logic rdy_pulldown_en,
    input wire logic data7_pulldown_en,
    input wire logic vbus_pulldown_en,
    input wire logic [6:0] bus_pullup_en,
    input wire logic [6:0] bus_pulldown_en
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    wire fw = xwr && xaddr == PPC_FUNC_OFFSET;
    a_irq_pullup: assert property (fw && xwdata[1:0] == 2'h1 |=> irq_pullup_en && !irq_pulldown_en)
        else $error("irq pullup wrong");
    a_irq_off: assert property (fw && xwdata[1] |=> !irq_pullup_en && !irq_pulldown_en)
        else $error("irq off wrong");
    a_rdy_pulldown: assert property (fw && xwdata[3:2] == 2'h0 |=> rdy_pulldown_en)
        else $error("ready pulldown wrong");
    a_d7_pd_off: assert property (fw && xwdata[7] |=> !data7_pulldown_en)
        else $error("data7 pulldown wrong");
    a_vbus_pd_on: assert property (fw && !xwdata[6] |=> vbus_pulldown_en)
        else $error("vbus pulldown wrong");
    a_bus_exclusive: assert property ((bus_pullup_en & bus_pulldown_en) == 7'h00)
        else $error("bus pull both on");
    a_hard_reset: assert property (bus_hard_reset_bit |=> !bus_pullup_en[6])
        else $error("bus reset pullup kept");
    a_sel_rsv: assert property (xrd && xaddr == PPC_SEL_OFFSET |=> !xrdata[7])
        else $error("reserved bit read 1");
    cover property (fw);
    cover property (bus_hard_reset_bit);
    cover property (xrd && xaddr == PPC_SEL_OFFSET);
endmodule : ppc_checker
bind ppc_pad_pull_config ppc_checker chk (.*);
`default_nettype wire

// ---- test/ppc_pad_pull_config_bench.sv ----
// self-checking bench for the pad pull configuration bank
`timescale 1ns/10ps
`default_nettype none
module ppc_pad_pull_config_bench;
    import ppc_pkg::*;
    logic mclk = 0, rst = 1, xwr = 0, xrd = 0, bus_hard_reset_bit = 0;
    logic [15:0] xaddr = 16'h0000;
    logic [7:0] xwdata = 8'h00, xrdata, f, s, p, rexp;
    logic [21:0] pexp;
    logic irq_pullup_en, irq_pulldown_en, rdy_pullup_en, rdy_pulldown_en;
    logic dmarq_pulldown_en, data_pulldown_en, data7_pulldown_en, vbus_pulldown_en;
    logic [6:0] bus_pullup_en, bus_pulldown_en;
    logic [15:0] tbl [4] = '{PPC_FUNC_OFFSET, PPC_SEL_OFFSET, PPC_PWDN_OFFSET, 16'hf091};
    int n_fail = 0, checks_done = 0, op;
    wire [21:0] pads = {irq_pullup_en, irq_pulldown_en, rdy_pullup_en, rdy_pulldown_en, dmarq_pulldown_en,
        data_pulldown_en, data7_pulldown_en, vbus_pulldown_en, bus_pullup_en, bus_pulldown_en};
    ppc_pad_pull_config dut (.*);
    initial forever #10 mclk = ~mclk;
    task check(string nm, logic [21:0] seen, logic [21:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task look();
        pexp = {f[0] & ~f[1], ~f[0] & ~f[1], f[2] & ~f[3], ~f[2] & ~f[3], ~f[4], ~f[5], ~f[7], ~f[6],
            s[6:0] & ~p[6:0], ~s[6:0] & ~p[6:0]};
        check("pads", pads, pexp);
        check("xrdata", 22'(xrdata), 22'(rexp));
    endtask : look
    task step(logic w, logic r, logic h, logic [15:0] a, logic [7:0] d);
        xwr = w;
        xrd = r;
        bus_hard_reset_bit = h;
        xaddr = a;
        xwdata = d;
        @(negedge mclk);
        if (w && a == PPC_FUNC_OFFSET) f = d;
        if (w && a == PPC_SEL_OFFSET) s = d & 8'h7f;
        if (w && a == PPC_PWDN_OFFSET) p = d & 8'h7f;
        if (h) s[6] = 1'b0;
        if (r) rexp = a == PPC_FUNC_OFFSET ? f : a == PPC_SEL_OFFSET ? s : a == PPC_PWDN_OFFSET ? p : 8'h00;
        look();
    endtask : step
    task rst_seq(int n);
        rst = 1;
        {f, s, p, rexp} = 32'h00000000;
        repeat (n) @(negedge mclk);
        look();
        rst = 0;
    endtask : rst_seq
    task give_verdict();
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        void'($urandom(93904));
        rst_seq(20);
        step(1, 0, 0, PPC_SEL_OFFSET, 8'hff);
        step(0, 1, 0, PPC_SEL_OFFSET, 8'h00);
        step(1, 0, 1, PPC_SEL_OFFSET, 8'hff);
        step(1, 0, 0, PPC_FUNC_OFFSET, 8'h44);
        step(1, 0, 0, PPC_PWDN_OFFSET, 8'h55);
        repeat (2)
        begin
            repeat (400)
            begin
                op = $urandom % 4;
                step(op == 0 || op == 2, op == 1, op > 1, ($urandom % 5 == 4) ? 16'($urandom) : tbl[$urandom % 4],
                    8'($urandom));
            end
            rst_seq(2);
        end
        step(0, 0, 0, 16'h0000, 8'h00);
        give_verdict();
    end
endmodule : ppc_pad_pull_config_bench
`default_nettype wire
